// ---- testbench/spi_peer_slave.sv ----
// Purpose: Peer slave on the far side of the link
// Assumes: Mode 1 (clock idles low, launch on rise, sample on fall)
// Notes:   Released data line shows the inverse of its last bit
`timescale 1ns/1ps
module spi_peer_slave (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic [7:0] send,
  output      logic       miso,
  output      logic [7:0] got
);
  logic [7:0] shift_reg = 8'h00;
  logic       last_bit  = 1'b0;
  always @(negedge sel_n) shift_reg = send;
  always @(posedge sck) if (!sel_n) begin
    last_bit  = shift_reg[7];
    shift_reg = {shift_reg[6:0], 1'b0};
  end
  always @(negedge sck) if (!sel_n) got = {got[6:0], mosi};
  assign miso = sel_n ? ~last_bit : last_bit;
endmodule // spi_peer_slave

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the serial register block
// Assumes: Master operation at rate code 1 against a mode 1 peer
// Notes:   Slave path is left idle; clock line has a pull-down
`timescale 1ns/1ps
module testbench;
  localparam logic [15:0] CTL = spi_regs_pkg::OFS_CONTROL;
  localparam logic [15:0] STS = spi_regs_pkg::OFS_STATUS_CTRL;
  localparam logic [15:0] DAT = spi_regs_pkg::OFS_DATA;
  logic        sys_clk = 1'b0, srst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wr_data = 8'h00, rd_data, q, tx, px, old_px, peer_send = 8'h00, peer_got;
  logic        irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, sel_pin_locked;
  logic        sel_n_in = 1'b1, peer_sel_n = 1'b1, sck_q = 1'b0, miso_w;
  int          errors = 0, checked = 0, cycles = 0, run = 0, half = 0, edges = 0, e0;
  logic [31:0] seed = 32'h49;
  wire         sck_w  = sck_oe ? sck_out : 1'b0;
  wire         mosi_w = mosi_oe ? mosi_out : 1'b1;
  always #50 sys_clk = ~sys_clk;
  spi_control_status_data_regs i_spi_control_status_data_regs (.sys_clk(sys_clk),
    .srst(srst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_data(rd_data), .irq(irq), .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_in(miso_oe ? miso_out : miso_w), .miso_out(miso_out), .miso_oe(miso_oe),
    .sel_n_in(sel_n_in), .sel_pin_locked(sel_pin_locked));
  spi_peer_slave i_spi_peer_slave (.sck(sck_w), .mosi(mosi_w), .sel_n(peer_sel_n),
    .send(peer_send), .miso(miso_w), .got(peer_got));
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    sck_q  <= sck_out;
    run    <= (sck_out !== sck_q) ? 1 : run + 1;
    if (sck_out !== sck_q) begin
      half  <= run;
      edges <= edges + 1;
    end
    if (cycles == 20000) begin
      errors = errors + 1;
      report_and_stop();
    end
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic chk(input string name, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, s);
    end
  endtask
  // One strobe cycle; read data taken in the cycle after the strobe
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= w;
    rd_stb  <= !w;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    @(negedge sys_clk);
    q = rd_data;
    @(posedge sys_clk);
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e, input string name);
    bus(1'b0, a, 8'h00);
    chk(name, q, e);
  endtask
  task automatic xfer(input logic [15:0] a, input logic [7:0] d, input logic [7:0] t);
    peer_send  <= px;
    peer_sel_n <= 1'b0;
    e0 = edges;
    bus(1'b1, a, d);
    for (int i = 0; i < 400 && edges - e0 < 16; i++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    peer_sel_n <= 1'b1;
    chk("edges", 8'(edges - e0), 8'h10);
    chk("half period", 8'(half), 8'h08);
    chk("peer got", peer_got, t);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rchk(CTL, 8'h28, "control reset");
    rchk(STS, 8'h08, "status reset");
    rchk(16'h0013, 8'h00, "unmapped");
    chk("irq", {7'h00, irq}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      tx = rnd() & 8'hbd;
      bus(1'b1, CTL, tx);
      rchk(CTL, tx, "control rw");
    end
    bus(1'b1, STS, 8'hff);
    rchk(STS, 8'h4f, "status rw");
    bus(1'b1, STS, 8'h01);
    bus(1'b1, CTL, 8'h00);
    tx = rnd();
    px = rnd();
    bus(1'b1, DAT, tx);
    rchk(STS, 8'h01, "tx empty low");
    xfer(CTL, 8'haa, tx);
    chk("irq rx", {7'h00, irq}, 8'h01);
    chk("locked", {7'h00, sel_pin_locked}, 8'h00);
    chk("idle clock", {7'h00, sck_out}, 8'h00);
    rchk(STS, 8'h89, "status full");
    rchk(DAT, px, "rx data");
    rchk(STS, 8'h09, "status clear");
    bus(1'b1, CTL, 8'h2a);
    bus(1'b1, STS, 8'h41);
    old_px = rnd();
    px = old_px;
    tx = rnd();
    xfer(DAT, tx, tx);
    chk("irq quiet", {7'h00, irq}, 8'h00);
    tx = rnd();
    px = rnd();
    xfer(DAT, tx, tx);
    chk("irq error", {7'h00, irq}, 8'h01);
    rchk(STS, 8'he9, "overrun");
    rchk(DAT, old_px, "kept byte");
    rchk(STS, 8'h49, "overrun clear");
    bus(1'b1, STS, 8'h05);
    chk("locked", {7'h00, sel_pin_locked}, 8'h01);
    sel_n_in <= 1'b0;
    q = 8'h00;
    for (int i = 0; i < 20 && q[4] !== 1'b1; i++) bus(1'b0, STS, 8'h00);
    chk("mode fault", q, 8'h1d);
    rchk(CTL, 8'h28, "disabled");
    sel_n_in <= 1'b1;
    bus(1'b1, STS, 8'h01);
    rchk(STS, 8'h19, "fault kept");
    bus(1'b1, CTL, 8'h2a);
    rchk(STS, 8'h09, "fault clear");
    report_and_stop();
  end
endmodule // testbench

// ---- verilog/spi_control_status_data_regs.sv ----
// Purpose: Serial peripheral block: control, status and data registers plus shifter
// Assumes: One clock; pins pass two flip-flops before use
// Notes:   Link clock in slave operation is sampled, not used as a clock
//
// Notes on behaviour
// - Receive-full interrupt only when receive enable set
// - Master select bit picks master; reset sets it
// - Polarity sets idle clock level; reset clears
// - Phase picks edge timing; reset sets it
// - Wired-or mode makes clock and data open-drain
// - Enable bit; clearing gives partial reset
// - Transmit-empty interrupt only when transmit enable set
// - Receive-full set when byte reaches receive register
// - Receive-full clears by status read then data read
// - Error enable gates overrun and mode-fault interrupts
// - Overrun keeps old byte, drops new one
// - Overrun clears by status read then data read
// - Mode fault on select misuse when enabled
// - Mode fault clears by status read, control write
// - Transmit-empty set on handoff, cleared by write
// - Fault enable clear keeps flag; master ignores select
// - Select pin locked from general use when used
// - Master rate divisor 2, 8, 32, 128
// - Separate transmit and receive data registers, unreset
// - Deselected slave floats data out, ignores clock
// - One byte full duplex in eight clocks
`timescale 1ns/1ps

module spi_control_status_data_regs (
  input  wire logic                             sys_clk,
  input  wire logic                             srst,
  input  wire logic [spi_regs_pkg::ADDR_W-1:0]  addr,
  input  wire logic [7:0]                       wr_data,
  input  wire logic                             wr_stb,
  input  wire logic                             rd_stb,
  output      logic [7:0]                       rd_data,
  output      logic                             irq,
  input  wire logic                             sck_in,
  output      logic                             sck_out,
  output      logic                             sck_oe,
  input  wire logic                             mosi_in,
  output      logic                             mosi_out,
  output      logic                             mosi_oe,
  input  wire logic                             miso_in,
  output      logic                             miso_out,
  output      logic                             miso_oe,
  input  wire logic                             sel_n_in,
  output      logic                             sel_pin_locked
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic                      rx_irq_enable;
    logic                      master_select;
    logic                      clock_polarity;
    logic                      clock_phase;
    logic                      wired_or_mode;
    logic                      module_enable;
    logic                      tx_irq_enable;
    logic                      error_irq_enable;
    logic                      mode_fault_enable;
    logic [1:0]                rate;
    logic                      rx_full_flag;
    logic                      overrun_flag;
    logic                      mode_fault_flag;
    logic                      tx_empty_flag;
    logic                      arm_rx;
    logic                      arm_ovr;
    logic                      arm_mode_fault_flag;
    logic [7:0]                tx_buf;
    logic [7:0]                rx_buf;
    logic [7:0]                shift;
    logic                      out_bit;
    logic [2:0]                bit_cnt;
    logic [3:0]                edge_cnt;
    logic [6:0]                div_cnt;
    logic                      sck_lvl;
    logic                      wait_desel;
    spi_regs_pkg::xfer_state_e state;
    logic                      sck_s1, sck_s2, sck_s3;
    logic                      mosi_s1, mosi_s2;
    logic                      miso_s1, miso_s2;
    logic                      sel_s1, sel_s2;
    logic [2:0]                pin_o;
    logic [2:0]                pin_oe;
    logic                      lock;
    logic                      irq_q;
    logic [7:0]                rdata;
  } state_s;

  state_s r_reg;
  state_s r_next;

  assign rd_data        = r_reg.rdata;
  assign irq            = r_reg.irq_q;
  assign sck_out        = r_reg.pin_o[spi_regs_pkg::P_SCK];
  assign sck_oe         = r_reg.pin_oe[spi_regs_pkg::P_SCK];
  assign mosi_out       = r_reg.pin_o[spi_regs_pkg::P_MOSI];
  assign mosi_oe        = r_reg.pin_oe[spi_regs_pkg::P_MOSI];
  assign miso_out       = r_reg.pin_o[spi_regs_pkg::P_MISO];
  assign miso_oe        = r_reg.pin_oe[spi_regs_pkg::P_MISO];
  assign sel_pin_locked = r_reg.lock;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic       lead;
    logic       trail;
    logic       samp;
    logic       launch;
    logic       din;
    logic       done;
    logic       is_mst;
    logic       is_slv;
    logic [6:0] div_lim;
    logic [7:0] byte_in;
    logic [2:0] drive;
    logic [2:0] val;
    r_next  = r_reg;
    lead    = 1'h0;
    trail   = 1'h0;
    done    = 1'h0;
    is_mst  = r_reg.module_enable & r_reg.master_select;
    is_slv  = r_reg.module_enable & ~r_reg.master_select;
    din     = r_reg.master_select ? r_reg.miso_s2 : r_reg.mosi_s2;
    byte_in = {r_reg.shift[6:0], din};
    drive   = 3'h0;
    val     = 3'h0;
    samp    = 1'h0;
    launch  = 1'h0;
    div_lim = 7'h00;

    // Pin synchronisers: stage one feeds stage two; clock adds a third stage for edge detection
    r_next.sck_s1  = sck_in;
    r_next.sck_s2  = r_reg.sck_s1;
    r_next.sck_s3  = r_reg.sck_s2;
    r_next.mosi_s1 = mosi_in;
    r_next.mosi_s2 = r_reg.mosi_s1;
    r_next.miso_s1 = miso_in;
    r_next.miso_s2 = r_reg.miso_s1;
    r_next.sel_s1  = sel_n_in;
    r_next.sel_s2  = r_reg.sel_s1;

    unique case (r_reg.rate)
      2'h0: div_lim = spi_regs_pkg::DIV_LIM0;
      2'h1: div_lim = spi_regs_pkg::DIV_LIM1;
      2'h2: div_lim = spi_regs_pkg::DIV_LIM2;
      2'h3: div_lim = spi_regs_pkg::DIV_LIM3;
    endcase

    // master clock generation, toggle every divisor base cycles
    if (is_mst && r_reg.state == spi_regs_pkg::ST_RUN) begin
      if (r_reg.div_cnt == div_lim) begin
        r_next.div_cnt  = 7'h00;
        r_next.sck_lvl  = ~r_reg.sck_lvl;
        r_next.edge_cnt = r_reg.edge_cnt + 4'h1;
        lead            = (r_reg.sck_lvl == r_reg.clock_polarity);
        trail           = ~lead;
        if (r_reg.edge_cnt == spi_regs_pkg::LAST_EDGE) begin
          r_next.state = spi_regs_pkg::ST_IDLE;
        end
      end else begin
        r_next.div_cnt = r_reg.div_cnt + 7'h01;
      end
    end

    // slave follows clock edges only while selected
    if (is_slv && r_reg.state == spi_regs_pkg::ST_RUN && !r_reg.sel_s2) begin
      if (r_reg.sck_s2 != r_reg.sck_s3) begin
        lead  = (r_reg.sck_s2 != r_reg.clock_polarity);
        trail = ~lead;
      end
    end

    // phase picks the sampling and launching edges, msb first
    samp   = r_reg.clock_phase ? trail : lead;
    launch = r_reg.clock_phase ? lead : trail;
    if (samp) begin
      r_next.shift   = byte_in;
      r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
      done = (r_reg.bit_cnt == spi_regs_pkg::LAST_BIT);
    end
    if (launch) begin
      r_next.out_bit = r_reg.shift[7];
    end

    if (done && is_slv) begin
      r_next.state      = spi_regs_pkg::ST_IDLE;
      // phase 0 slave waits for the peer to deselect
      r_next.wait_desel = ~r_reg.clock_phase;
    end
    if (r_reg.sel_s2) begin
      r_next.wait_desel = 1'h0;
    end

    // transmit register hands its byte to the shifter
    if (r_reg.state == spi_regs_pkg::ST_IDLE &&
        ((is_mst && !r_reg.tx_empty_flag) ||
         (is_slv && !r_reg.sel_s2 && !r_reg.wait_desel))) begin
      r_next.shift    = r_reg.tx_buf;
      r_next.out_bit  = r_reg.tx_buf[7];
      r_next.bit_cnt  = 3'h0;
      r_next.edge_cnt = 4'h0;
      r_next.div_cnt  = 7'h00;
      r_next.state    = spi_regs_pkg::ST_RUN;
    end

    // slave deselected mid-byte aborts and may fault
    if (is_slv && r_reg.state == spi_regs_pkg::ST_RUN && r_reg.sel_s2) begin
      r_next.state = spi_regs_pkg::ST_IDLE;
    end

    // disabled module drops any transfer, clock back to idle
    if (!r_reg.module_enable) begin
      r_next.state      = spi_regs_pkg::ST_IDLE;
      r_next.wait_desel = 1'h0;
    end
    if (r_next.state == spi_regs_pkg::ST_IDLE) begin
      r_next.sck_lvl = r_next.clock_polarity;
    end

    // ****************************************************************
    // Register port
    // ****************************************************************
    r_next.rdata = 8'h00;
    if (wr_stb) begin
      unique case (addr)
        spi_regs_pkg::OFS_CONTROL: begin
          r_next.rx_irq_enable  = wr_data[spi_regs_pkg::B_RX_IE];
          r_next.master_select  = wr_data[spi_regs_pkg::B_MASTER];
          r_next.clock_polarity = wr_data[spi_regs_pkg::B_CLOCK_POLARITY];
          r_next.clock_phase    = wr_data[spi_regs_pkg::B_CLOCK_PHASE];
          r_next.wired_or_mode  = wr_data[spi_regs_pkg::B_WOM];
          r_next.module_enable  = wr_data[spi_regs_pkg::B_EN];
          r_next.tx_irq_enable  = wr_data[spi_regs_pkg::B_TX_IE];
          // second step of the fault clear
          if (r_reg.arm_mode_fault_flag) begin
            r_next.mode_fault_flag = 1'h0;
            r_next.arm_mode_fault_flag        = 1'h0;
          end
        end
        spi_regs_pkg::OFS_STATUS_CTRL: begin
          r_next.error_irq_enable  = wr_data[spi_regs_pkg::B_ERR_IE];
          r_next.mode_fault_enable = wr_data[spi_regs_pkg::B_MODE_FAULT_FLAG_EN];
          r_next.rate = {wr_data[spi_regs_pkg::B_RATE_HI], wr_data[spi_regs_pkg::B_RATE_LO]};
        end
        spi_regs_pkg::OFS_DATA: begin
          // write lands in the transmit register only
          r_next.tx_buf        = wr_data;
          r_next.tx_empty_flag = 1'h0;
        end
        default: begin
        end
      endcase
    end
    if (rd_stb) begin
      unique case (addr)
        spi_regs_pkg::OFS_CONTROL: begin
          r_next.rdata[spi_regs_pkg::B_RX_IE]  = r_reg.rx_irq_enable;
          r_next.rdata[spi_regs_pkg::B_MASTER] = r_reg.master_select;
          r_next.rdata[spi_regs_pkg::B_CLOCK_POLARITY]   = r_reg.clock_polarity;
          r_next.rdata[spi_regs_pkg::B_CLOCK_PHASE]   = r_reg.clock_phase;
          r_next.rdata[spi_regs_pkg::B_WOM]    = r_reg.wired_or_mode;
          r_next.rdata[spi_regs_pkg::B_EN]     = r_reg.module_enable;
          r_next.rdata[spi_regs_pkg::B_TX_IE]  = r_reg.tx_irq_enable;
        end
        spi_regs_pkg::OFS_STATUS_CTRL: begin
          r_next.rdata[spi_regs_pkg::B_RX_FULL]  = r_reg.rx_full_flag;
          r_next.rdata[spi_regs_pkg::B_ERR_IE]   = r_reg.error_irq_enable;
          r_next.rdata[spi_regs_pkg::B_OVERRUN]  = r_reg.overrun_flag;
          r_next.rdata[spi_regs_pkg::B_MODE_FAULT_FLAG]     = r_reg.mode_fault_flag;
          r_next.rdata[spi_regs_pkg::B_TX_EMPTY] = r_reg.tx_empty_flag;
          r_next.rdata[spi_regs_pkg::B_MODE_FAULT_FLAG_EN]  = r_reg.mode_fault_enable;
          r_next.rdata[spi_regs_pkg::B_RATE_HI]  = r_reg.rate[1];
          r_next.rdata[spi_regs_pkg::B_RATE_LO]  = r_reg.rate[0];
          // first step arms the flag clears
          r_next.arm_rx   = r_reg.rx_full_flag;
          r_next.arm_ovr  = r_reg.overrun_flag;
          r_next.arm_mode_fault_flag = r_reg.mode_fault_flag;
        end
        spi_regs_pkg::OFS_DATA: begin
          r_next.rdata = r_reg.rx_buf;
          if (r_reg.arm_rx) begin
            r_next.rx_full_flag = 1'h0;
            r_next.arm_rx       = 1'h0;
          end
          if (r_reg.arm_ovr) begin
            r_next.overrun_flag = 1'h0;
            r_next.arm_ovr      = 1'h0;
          end
        end
        default: begin
        end
      endcase
    end

    // ****************************************************************
    // Flag sets, placed last so a set beats a same-cycle clear
    // ****************************************************************
    if (r_reg.state == spi_regs_pkg::ST_IDLE && r_next.state == spi_regs_pkg::ST_RUN) begin
      r_next.tx_empty_flag = 1'h1;
    end
    if (done) begin
      if (r_reg.rx_full_flag) begin
        r_next.overrun_flag = 1'h1;
      end else begin
        // completed byte fills the receive register
        r_next.rx_buf       = byte_in;
        r_next.rx_full_flag = 1'h1;
      end
    end
    if (is_slv && r_reg.state == spi_regs_pkg::ST_RUN && r_reg.sel_s2 &&
        r_reg.mode_fault_enable) begin
      r_next.mode_fault_flag = 1'h1;
    end
    // master sees select only with fault detection on; fault shuts master off
    if (is_mst && r_reg.mode_fault_enable && !r_reg.sel_s2) begin
      r_next.mode_fault_flag = 1'h1;
      r_next.module_enable   = 1'h0;
      r_next.state           = spi_regs_pkg::ST_IDLE;
      r_next.sck_lvl         = r_reg.clock_polarity;
    end

    // ****************************************************************
    // Pin drive and interrupt
    // ****************************************************************
    drive[spi_regs_pkg::P_SCK]  = r_next.module_enable & r_next.master_select;
    drive[spi_regs_pkg::P_MOSI] = r_next.module_enable & r_next.master_select;
    drive[spi_regs_pkg::P_MISO] = r_next.module_enable & ~r_next.master_select &
                                  ~r_reg.sel_s2;
    val[spi_regs_pkg::P_SCK]    = r_next.sck_lvl;
    val[spi_regs_pkg::P_MOSI]   = r_next.out_bit;
    val[spi_regs_pkg::P_MISO]   = r_next.out_bit;
    for (int i = 0; i < 3; i++) begin
      if (r_next.wired_or_mode) begin
        r_next.pin_o[i]  = 1'h0;
        r_next.pin_oe[i] = drive[i] & ~val[i];
      end else begin
        r_next.pin_o[i]  = val[i];
        r_next.pin_oe[i] = drive[i];
      end
    end
    r_next.lock = r_next.module_enable &
                  (~r_next.master_select | r_next.mode_fault_enable);
    // receive and transmit gated by their own enables, overrun and mode fault by the error enable
    r_next.irq_q = (r_next.rx_full_flag & r_next.rx_irq_enable) |
                   (r_next.tx_empty_flag & r_next.tx_irq_enable) |
                   ((r_next.overrun_flag | r_next.mode_fault_flag) &
                    r_next.error_irq_enable);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r_reg               <= '0;
      r_reg.master_select <= spi_regs_pkg::RST_MASTER;
      r_reg.clock_phase   <= spi_regs_pkg::RST_CLOCK_PHASE;
      r_reg.tx_empty_flag <= spi_regs_pkg::RST_TX_EMPTY;
      r_reg.sel_s1        <= spi_regs_pkg::RST_SEL_IDLE;
      r_reg.sel_s2        <= spi_regs_pkg::RST_SEL_IDLE;
      // data registers keep their contents through reset
      r_reg.tx_buf        <= r_reg.tx_buf;
      r_reg.rx_buf        <= r_reg.rx_buf;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_reset_mode: assert property (@(posedge sys_clk) $fell(srst) |->
    r_reg.master_select && r_reg.clock_phase && !r_reg.module_enable &&
    r_reg.tx_empty_flag && !r_reg.clock_polarity && r_reg.rate == 2'h0)
    else $error("Bad control state after reset");
  a_rx_irq_gate: assert property (@(posedge sys_clk) disable iff (srst)
    (r_reg.rx_full_flag && !r_reg.rx_irq_enable && !r_reg.tx_irq_enable &&
     !r_reg.error_irq_enable) |-> !irq)
    else $error("Receive interrupt while disabled");
  a_err_irq_raise: assert property (@(posedge sys_clk) disable iff (srst)
    (r_reg.overrun_flag && r_reg.error_irq_enable) [*2] |-> irq)
    else $error("Overrun with error enable gave no interrupt");
  a_overrun_keeps: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(r_reg.overrun_flag) |-> $stable(r_reg.rx_buf) && r_reg.rx_full_flag)
    else $error("Overrun disturbed the receive register");
  a_tx_handoff: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(r_reg.tx_empty_flag) |-> r_reg.state == spi_regs_pkg::ST_RUN)
    else $error("Transmit empty set without a handoff");
  a_miso_release: assert property (@(posedge sys_clk) disable iff (srst)
    (r_reg.sel_s2 && !r_reg.master_select) |=> !miso_oe)
    else $error("Deselected slave drives data out");
  a_mode_fault_flag_sticky: assert property (@(posedge sys_clk) disable iff (srst)
    (r_reg.mode_fault_flag && !(wr_stb && addr == spi_regs_pkg::OFS_CONTROL))
    |=> r_reg.mode_fault_flag)
    else $error("Mode fault lost without control write");
  a_rx_full_cause: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(r_reg.rx_full_flag) |-> $past(r_reg.bit_cnt) == spi_regs_pkg::LAST_BIT &&
    r_reg.bit_cnt == 3'h0)
    else $error("Receive full without eight bits");
  a_rate_edge: assert property (@(posedge sys_clk) disable iff (srst)
    (r_reg.state == spi_regs_pkg::ST_RUN && r_reg.module_enable && r_reg.master_select
     && $changed(r_reg.edge_cnt)) |-> $past(r_reg.div_cnt) != 7'h00 ||
     r_reg.rate == 2'h0)
    else $error("Master clock edge too early");
  a_sel_lock: assert property (@(posedge sys_clk) disable iff (srst)
    (r_reg.module_enable && !r_reg.master_select) [*2] |-> sel_pin_locked)
    else $error("Enabled slave left select pin free");

endmodule // spi_control_status_data_regs

// ---- verilog/spi_regs_pkg.sv ----
// Purpose: Shared constants for the serial peripheral register block
// Assumes: Byte-wide registers on a plain strobe port
// Notes:   Offsets are byte addresses on that port
package spi_regs_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          ADDR_W          = 16;
  localparam logic [15:0] OFS_CONTROL     = 16'h0010;
  localparam logic [15:0] OFS_STATUS_CTRL = 16'h0011;
  localparam logic [15:0] OFS_DATA        = 16'h0012;

  // Control register bit positions
  localparam int B_RX_IE  = 7;
  localparam int B_MASTER = 5;
  localparam int B_CLOCK_POLARITY   = 4;
  localparam int B_CLOCK_PHASE   = 3;
  localparam int B_WOM    = 2;
  localparam int B_EN     = 1;
  localparam int B_TX_IE  = 0;

  // Status and control register bit positions
  localparam int B_RX_FULL  = 7;
  localparam int B_ERR_IE   = 6;
  localparam int B_OVERRUN  = 5;
  localparam int B_MODE_FAULT_FLAG     = 4;
  localparam int B_TX_EMPTY = 3;
  localparam int B_MODE_FAULT_FLAG_EN  = 2;
  localparam int B_RATE_HI  = 1;
  localparam int B_RATE_LO  = 0;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic RST_MASTER   = 1'h1;
  localparam logic RST_CLOCK_PHASE     = 1'h1;
  localparam logic RST_TX_EMPTY = 1'h1;
  localparam logic RST_SEL_IDLE = 1'h1;

  // Master rate divisors for rate codes 0..3, as count limits (divisor - 1)
  localparam logic [6:0] DIV_LIM0 = 7'h01;
  localparam logic [6:0] DIV_LIM1 = 7'h07;
  localparam logic [6:0] DIV_LIM2 = 7'h1f;
  localparam logic [6:0] DIV_LIM3 = 7'h7f;

  localparam logic [2:0] LAST_BIT  = 3'h7;
  localparam logic [3:0] LAST_EDGE = 4'hf;

  // Pin slots in the pin vectors
  localparam int P_SCK  = 0;
  localparam int P_MOSI = 1;
  localparam int P_MISO = 2;

  typedef enum logic {ST_IDLE, ST_RUN} xfer_state_e;

endpackage
